// >>> rtl/sas_pkg.sv
// Shared constants for the SUCCESSIVE_APPROX_REG converter sequencer.
// Assumes a byte-wide CPU register port and a 100 MHz main clock.
package sas_pkg;
  // Register addresses
  localparam logic [15:0] MODE_ADDR = 16'hff80;
  localparam logic [15:0] CHAN_ADDR = 16'hff81;
  localparam logic [15:0] RES_LO_ADDR = 16'hff0e;
  localparam logic [15:0] RES_HI_ADDR = 16'hff0f;
  // Reset values
  localparam logic [7:0] MODE_RST = 8'h00;
  localparam logic [2:0] CHAN_RST = 3'h0;
  localparam logic [9:0] RES_RST = 10'h000;
  // Mode register fields
  localparam int CONV_EN_BIT = 7;
  localparam int TRIG_SEL_BIT = 6;
  localparam int TIME_SEL_MSB = 5;
  localparam int TIME_SEL_LSB = 3;
  localparam int EDGE_SEL_MSB = 2;
  localparam int EDGE_SEL_LSB = 1;
  localparam int BOOST_EN_BIT = 0;
  // Trigger edge codes
  localparam logic [1:0] EDGE_NONE = 2'h0;
  localparam logic [1:0] EDGE_FALL = 2'h1;
  localparam logic [1:0] EDGE_RISE = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;
  // Conversion lengths in main-clock periods per time code
  localparam logic [9:0] CONV_144 = 10'h090;
  localparam logic [9:0] CONV_120 = 10'h078;
  localparam logic [9:0] CONV_96 = 10'h060;
  localparam logic [9:0] CONV_576 = 10'h240;
  localparam logic [9:0] CONV_480 = 10'h1e0;
  localparam logic [9:0] CONV_384 = 10'h180;
  // A conversion is 12 slots: 2 for sampling, 1 per bit decision
  localparam int SLOTS_PER_CONV = 12;
  localparam int SAMPLE_SLOTS = 2;
  // Result layout
  localparam int RES_BITS = 10;
  localparam logic [9:0] SAR_MSB_ONLY = 10'h200;
  localparam logic [3:0] SAR_TOP_IDX = 4'h9;
  // Reference booster settle time
  localparam int CLK_PERIOD_NS = 10;
  localparam int BOOST_SETTLE_NS = 14000;
  localparam int BOOST_SETTLE_CYC = (BOOST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  typedef enum logic [1:0] {ST_IDLE, ST_WAIT_TRIG, ST_SAMPLE, ST_CONVERT} sas_state_type;
endpackage

// >>> rtl/sas_sequencer.sv
// Sequencer for an 8-input 10-bit successive-approximation converter.
// Assumes a CPU byte port at fixed addresses, an external sample-hold,
// comparator and tap selector, and a trigger input that may be asynchronous to clk_i.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer
  import sas_pkg::*;
(
  // Clock and reset
  input wire logic clk_i,
  input wire logic rst_b_i,
  // CPU register port
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  output logic [7:0] rdata_o,
  // Status and system
  input wire logic standby_i,
  input wire logic conv_done_flag_clr_i,
  output logic conv_done_flag_o,
  output logic conv_done_irq_o,
  output logic result_unsettled_o,
  // Trigger
  input wire logic ext_conv_trigger_i,
  // Analog front end
  input wire logic comp_ge_i,
  output logic [2:0] analog_sel_o,
  output logic hold_o,
  output logic [9:0] tap_o,
  output logic booster_on_o
);

  sas_state_type state_r, state_nxt;
  logic [7:0] adc_mode_reg_r, adc_mode_reg_nxt;
  logic [2:0] adc_channel_select_r, adc_channel_select_nxt;
  logic [9:0] successive_approx_reg_r, successive_approx_reg_nxt;
  logic [3:0] bit_idx_r, bit_idx_nxt;
  logic [9:0] cnt_r, cnt_nxt;
  logic [9:0] conv_result_reg_r, conv_result_reg_nxt;
  logic conv_done_flag_r, conv_done_flag_nxt;
  logic conv_done_irq_r, conv_done_irq_nxt;
  logic hold_r, hold_nxt;
  logic [7:0] rdata_r, rdata_nxt;
  logic trig_s1_r, trig_s2_r, trig_d_r;
  logic [10:0] boost_cnt_r, boost_cnt_nxt;
  logic boost_ready_r, boost_ready_nxt;
  logic pending_bad_r, pending_bad_nxt;
  logic unsettled_r, unsettled_nxt;

  logic mode_wr, chan_wr, reg_wr, conv_en, trig_mode, trig_edge, done_evt;
  logic [9:0] conv_len, step_len, sample_len, sar_dec, trial_bit;
  logic [1:0] edge_sel;

  assign mode_wr = wr_i && (addr_i == MODE_ADDR);
  assign chan_wr = wr_i && (addr_i == CHAN_ADDR);
  assign reg_wr = mode_wr || chan_wr;
  assign conv_en = adc_mode_reg_r[CONV_EN_BIT];
  assign trig_mode = adc_mode_reg_r[TRIG_SEL_BIT];
  assign edge_sel = adc_mode_reg_r[EDGE_SEL_MSB:EDGE_SEL_LSB];

  // Prohibited time codes fall back to the code 0 length of 144 periods
  always_comb
  begin
    case (adc_mode_reg_r[TIME_SEL_MSB:TIME_SEL_LSB])
      3'h0: conv_len = CONV_144;
      3'h1: conv_len = CONV_120;
      3'h2: conv_len = CONV_96;
      3'h4: conv_len = CONV_576;
      3'h5: conv_len = CONV_480;
      3'h6: conv_len = CONV_384;
      default: conv_len = CONV_144;
    endcase
  end

  // Sampling plus ten bit steps add up to the full conversion time
  assign step_len = conv_len / 10'(SLOTS_PER_CONV);
  assign sample_len = 10'(SAMPLE_SLOTS) * step_len;

  // The second stage and its delayed copy feed edge detection
  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      trig_s1_r <= 1'b0;
      trig_s2_r <= 1'b0;
      trig_d_r <= 1'b0;
    end
    else
    begin
      trig_s1_r <= ext_conv_trigger_i;
      trig_s2_r <= trig_s1_r;
      trig_d_r <= trig_s2_r;
    end
  end

  always_comb
  begin
    case (edge_sel)
      EDGE_FALL: trig_edge = trig_d_r && !trig_s2_r;
      EDGE_RISE: trig_edge = !trig_d_r && trig_s2_r;
      EDGE_BOTH: trig_edge = trig_d_r != trig_s2_r;
      default: trig_edge = 1'b0;
    endcase
  end

  // Current trial decided: keep bit only when input is at or above tap
  assign trial_bit = SAR_MSB_ONLY >> (SAR_TOP_IDX - bit_idx_r);
  assign sar_dec = comp_ge_i ? successive_approx_reg_r
                             : (successive_approx_reg_r & ~trial_bit);
  assign done_evt = (state_r == ST_CONVERT) && (cnt_r == 10'h000)
                    && (bit_idx_r == 4'h0) && !reg_wr && conv_en && !standby_i;

  // Register file and booster settling
  always_comb
  begin
    adc_mode_reg_nxt = adc_mode_reg_r;
    adc_channel_select_nxt = adc_channel_select_r;
    rdata_nxt = rdata_r;
    boost_cnt_nxt = boost_cnt_r;
    boost_ready_nxt = boost_ready_r;
    if (mode_wr)
      adc_mode_reg_nxt = wdata_i;
    if (chan_wr)
      adc_channel_select_nxt = wdata_i[2:0];
    if (rd_i)
    begin
      case (addr_i)
        MODE_ADDR: rdata_nxt = adc_mode_reg_r;
        CHAN_ADDR: rdata_nxt = {5'h00, adc_channel_select_r};
        RES_LO_ADDR: rdata_nxt = {conv_result_reg_r[1:0], 6'h00};
        RES_HI_ADDR: rdata_nxt = conv_result_reg_r[9:2];
        default: rdata_nxt = 8'h00;
      endcase
    end
    if (!adc_mode_reg_r[BOOST_EN_BIT])
    begin
      boost_cnt_nxt = 11'h000;
      boost_ready_nxt = 1'b0;
    end
    else if (boost_cnt_r == 11'(BOOST_SETTLE_CYC - 1))
      boost_ready_nxt = 1'b1;
    else
      boost_cnt_nxt = boost_cnt_r + 11'h001;
  end

  // Conversion sequence
  always_comb
  begin
    state_nxt = state_r;
    successive_approx_reg_nxt = successive_approx_reg_r;
    bit_idx_nxt = bit_idx_r;
    cnt_nxt = cnt_r;
    conv_result_reg_nxt = conv_result_reg_r;
    conv_done_irq_nxt = 1'b0;
    hold_nxt = hold_r;
    pending_bad_nxt = pending_bad_r;
    unsettled_nxt = unsettled_r;
    if (!conv_en || standby_i)
    begin
      state_nxt = ST_IDLE;
      hold_nxt = 1'b0;
      if (!conv_en)
        pending_bad_nxt = 1'b0;
    end
    else if (reg_wr)
    begin
      // Abort; idle restarts or re-arms the trigger next cycle
      state_nxt = ST_IDLE;
      hold_nxt = 1'b0;
    end
    else
    begin
      case (state_r)
        ST_IDLE:
        begin
          hold_nxt = 1'b0;
          cnt_nxt = sample_len - 10'h001;
          if (trig_mode)
            state_nxt = ST_WAIT_TRIG;
          else
            state_nxt = ST_SAMPLE;
        end
        ST_WAIT_TRIG:
        begin
          cnt_nxt = sample_len - 10'h001;
          if (trig_edge)
            state_nxt = ST_SAMPLE;
        end
        ST_SAMPLE:
        begin
          if (cnt_r == 10'h000)
          begin
            state_nxt = ST_CONVERT;
            hold_nxt = 1'b1;
            successive_approx_reg_nxt = SAR_MSB_ONLY;
            bit_idx_nxt = SAR_TOP_IDX;
            cnt_nxt = step_len - 10'h001;
          end
          else
            cnt_nxt = cnt_r - 10'h001;
        end
        ST_CONVERT:
        begin
          if (cnt_r != 10'h000)
            cnt_nxt = cnt_r - 10'h001;
          else if (bit_idx_r != 4'h0)
          begin
            successive_approx_reg_nxt = sar_dec | (trial_bit >> 1);
            bit_idx_nxt = bit_idx_r - 4'h1;
            cnt_nxt = step_len - 10'h001;
          end
          else
          begin
            successive_approx_reg_nxt = sar_dec;
            conv_result_reg_nxt = sar_dec;
            conv_done_irq_nxt = 1'b1;
            unsettled_nxt = pending_bad_r;
            pending_bad_nxt = 1'b0;
            hold_nxt = 1'b0;
            cnt_nxt = sample_len - 10'h001;
            // Trigger edges seen during conversion are dropped
            if (trig_mode)
              state_nxt = ST_WAIT_TRIG;
            else
              state_nxt = ST_SAMPLE;
          end
        end
        default:
          state_nxt = ST_IDLE;
      endcase
    end
    // Enabling conversion before the booster settles spoils the first result
    if (mode_wr && wdata_i[CONV_EN_BIT] && !conv_en && !boost_ready_r)
      pending_bad_nxt = 1'b1;
  end

  // Set beats a same-cycle clear so no completion is lost
  assign conv_done_flag_nxt = done_evt || (conv_done_flag_r && !conv_done_flag_clr_i);

  always_ff @(posedge clk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_r <= ST_IDLE;
      adc_mode_reg_r <= MODE_RST;
      adc_channel_select_r <= CHAN_RST;
      successive_approx_reg_r <= RES_RST;
      bit_idx_r <= 4'h0;
      cnt_r <= 10'h000;
      conv_result_reg_r <= RES_RST;
      conv_done_flag_r <= 1'b0;
      conv_done_irq_r <= 1'b0;
      hold_r <= 1'b0;
      rdata_r <= 8'h00;
      boost_cnt_r <= 11'h000;
      boost_ready_r <= 1'b0;
      pending_bad_r <= 1'b0;
      unsettled_r <= 1'b0;
    end
    else
    begin
      state_r <= state_nxt;
      adc_mode_reg_r <= adc_mode_reg_nxt;
      adc_channel_select_r <= adc_channel_select_nxt;
      successive_approx_reg_r <= successive_approx_reg_nxt;
      bit_idx_r <= bit_idx_nxt;
      cnt_r <= cnt_nxt;
      conv_result_reg_r <= conv_result_reg_nxt;
      conv_done_flag_r <= conv_done_flag_nxt;
      conv_done_irq_r <= conv_done_irq_nxt;
      hold_r <= hold_nxt;
      rdata_r <= rdata_nxt;
      boost_cnt_r <= boost_cnt_nxt;
      boost_ready_r <= boost_ready_nxt;
      pending_bad_r <= pending_bad_nxt;
      unsettled_r <= unsettled_nxt;
    end
  end

  assign rdata_o = rdata_r;
  assign conv_done_flag_o = conv_done_flag_r;
  assign conv_done_irq_o = conv_done_irq_r;
  assign result_unsettled_o = unsettled_r;
  assign analog_sel_o = adc_channel_select_r;
  assign hold_o = hold_r;
  // Tap tracks the SUCCESSIVE_APPROX_REG: decided upper bits plus the current trial bit
  assign tap_o = successive_approx_reg_r;
  assign booster_on_o = adc_mode_reg_r[BOOST_EN_BIT];

endmodule
`default_nettype wire

// >>> verification/sas_analog_model.sv
// Sample-hold, tap ladder and comparator model.
// Assumes the bench loads vin2 per input, in half-LSB units.
`timescale 1ns/1ps
`default_nettype none
module sas_analog_model (
  // Front-end controls
  input wire logic clk_i,
  input wire logic [2:0] analog_sel_i,
  input wire logic hold_i,
  input wire logic [9:0] tap_i,
  // Comparator
  output logic comp_ge_o
);
  logic [11:0] vin2 [8];
  logic [11:0] held_r;
  always_ff @(posedge clk_i)
  begin
    if (!hold_i)
    begin
      held_r <= vin2[analog_sel_i];
    end
  end
  // Tap k sits half an LSB below code k, so the search rounds
  assign comp_ge_o = ({1'b0, held_r} + 13'h001) >= {2'b00, tap_i, 1'b0};
endmodule
`default_nettype wire

// >>> verification/sas_sequencer_chk.sv
// Port checker for the converter sequencer.
// Assumes one clock domain and an async active-low reset.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_chk
  import sas_pkg::*;
(
  // Observed ports
  input wire logic clk_i,
  input wire logic rst_b_i,
  input wire logic [15:0] addr_i,
  input wire logic wr_i,
  input wire logic rd_i,
  input wire logic [7:0] wdata_i,
  input wire logic [7:0] rdata_o,
  input wire logic standby_i,
  input wire logic conv_done_flag_o,
  input wire logic conv_done_irq_o,
  input wire logic [2:0] analog_sel_o,
  input wire logic hold_o,
  input wire logic [9:0] tap_o,
  input wire logic booster_on_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_b_i);
  logic cw;
  logic mw;
  assign cw = wr_i && (addr_i == CHAN_ADDR);
  assign mw = wr_i && (addr_i == MODE_ADDR);
  property p_sel;
    cw |=> analog_sel_o == $past(wdata_i[2:0]);
  endproperty
  a_sel: assert property (p_sel) else $error("channel select wrong");
  property p_chan_hi;
    rd_i && addr_i == CHAN_ADDR |=> rdata_o[7:3] == 5'h00;
  endproperty
  a_chan_hi: assert property (p_chan_hi) else $error("channel upper bits set");
  property p_res_lo;
    rd_i && addr_i == RES_LO_ADDR |=> rdata_o[5:0] == 6'h00;
  endproperty
  a_res_lo: assert property (p_res_lo) else $error("result low bits set");
  property p_first_tap;
    $rose(hold_o) |-> tap_o == SAR_MSB_ONLY;
  endproperty
  a_first_tap: assert property (p_first_tap) else $error("first trial wrong");
  property p_held;
    conv_done_irq_o |-> $past(hold_o);
  endproperty
  a_held: assert property (p_held) else $error("done without hold");
  property p_pulse;
    conv_done_irq_o |=> !conv_done_irq_o;
  endproperty
  a_pulse: assert property (p_pulse) else $error("done not a pulse");
  property p_flag;
    conv_done_irq_o |-> conv_done_flag_o;
  endproperty
  a_flag: assert property (p_flag) else $error("flag missing");
  property p_abort;
    cw || mw |=> !conv_done_irq_o ##1 !hold_o;
  endproperty
  a_abort: assert property (p_abort) else $error("write did not abort");
  property p_standby;
    standby_i |=> !hold_o && !conv_done_irq_o;
  endproperty
  a_standby: assert property (p_standby) else $error("ran in standby");
  property p_boost;
    mw |=> booster_on_o == $past(wdata_i[BOOST_EN_BIT]);
  endproperty
  a_boost: assert property (p_boost) else $error("booster bit wrong");
  c_done: cover property (conv_done_irq_o);
  c_hold: cover property ($rose(hold_o));
  c_abort: cover property (hold_o && cw);
endmodule
bind sas_sequencer sas_sequencer_chk u_sas_sequencer_chk (.clk_i, .rst_b_i, .addr_i, .wr_i,
  .rd_i, .wdata_i, .rdata_o, .standby_i, .conv_done_flag_o, .conv_done_irq_o, .analog_sel_o,
  .hold_o, .tap_o, .booster_on_o);
`default_nettype wire

// >>> verification/sas_sequencer_tb.sv
// Bench for the converter sequencer with an analog front-end model.
// Assumes a 100 MHz clock; inputs change on the falling edge.
`timescale 1ns/1ps
`default_nettype none
module sas_sequencer_tb;
  import sas_pkg::*;
  logic clk_i, rst_b_i, wr_i, rd_i, standby_i, conv_done_flag_clr_i, ext_conv_trigger_i;
  logic comp_ge_i, conv_done_flag_o, conv_done_irq_o, result_unsettled_o, hold_o, booster_on_o;
  logic [15:0] addr_i;
  logic [7:0] wdata_i, rdata_o, d;
  logic [2:0] analog_sel_o;
  logic [9:0] tap_o;
  int fail_count = 0;
  int total_checks = 0;
  int cyc = 0;
  int n;
  logic [11:0] vin [8] = '{12'h000, 12'h001, 12'h002, 12'h3ff, 12'h7fe, 12'h7ff, 12'h400, 12'h309};
  logic [2:0] codes [6] = '{3'h0, 3'h1, 3'h2, 3'h4, 3'h5, 3'h6};
  logic [9:0] lens [6] = '{CONV_144, CONV_120, CONV_96, CONV_576, CONV_480, CONV_384};
  sas_sequencer u_sas_sequencer (.clk_i, .rst_b_i, .addr_i, .wr_i, .rd_i, .wdata_i, .rdata_o,
    .standby_i, .conv_done_flag_clr_i, .conv_done_flag_o, .conv_done_irq_o, .result_unsettled_o,
    .ext_conv_trigger_i, .comp_ge_i, .analog_sel_o, .hold_o, .tap_o, .booster_on_o);
  sas_analog_model u_sas_analog_model (.clk_i, .analog_sel_i(analog_sel_o), .hold_i(hold_o),
    .tap_i(tap_o), .comp_ge_o(comp_ge_i));
  initial
  begin
    clk_i = 1'b0;
    forever #5 clk_i = ~clk_i;
  end
  task automatic stop_test();
    $display("checks %0d mismatches %0d", total_checks, fail_count);
    if (fail_count == 0 && total_checks > 0)
    begin
      $display("RESULT: PASS");
    end
    else
    begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  // Whole run needs about 10000 cycles
  always @(posedge clk_i)
  begin
    cyc++;
    if (cyc > 30000)
    begin
      fail_count++;
      stop_test();
    end
  end
  task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic wr(input logic [15:0] a, input logic [7:0] v);
    @(negedge clk_i);
    addr_i = a;
    wdata_i = v;
    wr_i = 1'b1;
    @(negedge clk_i);
    wr_i = 1'b0;
  endtask
  task automatic rd(input logic [15:0] a, output logic [7:0] v);
    @(negedge clk_i);
    addr_i = a;
    rd_i = 1'b1;
    @(negedge clk_i);
    rd_i = 1'b0;
    v = rdata_o;
  endtask
  task automatic wait_irq(output int k);
    k = 0;
    while (conv_done_irq_o !== 1'b1 && k < 1500)
    begin
      @(negedge clk_i);
      k++;
    end
    chk("irq", 16'(conv_done_irq_o), 16'h1);
    @(negedge clk_i);
  endtask
  task automatic wait_hold();
    int k;
    k = 0;
    while (hold_o !== 1'b1 && k < 500)
    begin
      @(negedge clk_i);
      k++;
    end
    chk("hold", 16'(hold_o), 16'h1);
  endtask
  task automatic quiet(input int k);
    logic s;
    s = 1'b0;
    repeat (k)
    begin
      @(negedge clk_i);
      s = s | conv_done_irq_o;
    end
    chk("no irq", 16'(s), 16'h0);
  endtask
  task automatic res_chk(input logic [11:0] v);
    logic [7:0] h, l;
    rd(RES_HI_ADDR, h);
    rd(RES_LO_ADDR, l);
    chk("result", {h, l}, {(v >= 12'h7fe) ? 10'h3ff : 10'((v + 12'h1) >> 1), 6'h00});
  endtask
  initial
  begin
    {rst_b_i, wr_i, rd_i, standby_i, conv_done_flag_clr_i, ext_conv_trigger_i} = 6'h00;
    addr_i = 16'h0000;
    wdata_i = 8'h00;
    for (int i = 0; i < 8; i++) u_sas_analog_model.vin2[i] = vin[i];
    repeat (20) @(negedge clk_i);
    rst_b_i = 1'b1;
    rd(MODE_ADDR, d);
    chk("mode", 16'(d), 16'(MODE_RST));
    rd(CHAN_ADDR, d);
    chk("chan", 16'(d), 16'h0);
    res_chk(12'h000);
    for (int i = 0; i < 8; i++)
    begin
      wr(CHAN_ADDR, 8'hf8 | 8'(i));
      rd(CHAN_ADDR, d);
      chk("chan", 16'(d), 16'(i));
      chk("sel", 16'(analog_sel_o), 16'(i));
    end
    $display("test registers done");
    wr(MODE_ADDR, 8'h80);
    wait_irq(n);
    chk("unsettled", 16'(result_unsettled_o), 16'h1);
    wr(MODE_ADDR, 8'h01);
    repeat (1500) @(negedge clk_i);
    for (int k = 0; k < 6; k++)
    begin
      wr(MODE_ADDR, 8'h81 | {2'b00, codes[k], 3'b000});
      wait_irq(n);
      wait_irq(n);
      chk("period", 16'(n), 16'(lens[k]) - 16'h1);
    end
    chk("unsettled", 16'(result_unsettled_o), 16'h0);
    chk("booster", 16'(booster_on_o), 16'h1);
    wr(MODE_ADDR, 8'h81);
    for (int i = 0; i < 8; i++)
    begin
      wr(CHAN_ADDR, 8'(i));
      wait_irq(n);
      res_chk(vin[i]);
    end
    chk("flag", 16'(conv_done_flag_o), 16'h1);
    conv_done_flag_clr_i = 1'b1;
    @(negedge clk_i);
    conv_done_flag_clr_i = 1'b0;
    chk("flag", 16'(conv_done_flag_o), 16'h0);
    $display("test software start done");
    // Land a channel write on the very edge that would end the conversion
    wait_irq(n);
    conv_done_flag_clr_i = 1'b1;
    @(negedge clk_i);
    conv_done_flag_clr_i = 1'b0;
    repeat (140) @(negedge clk_i);
    wr(CHAN_ADDR, 8'h02);
    chk("collide irq", 16'(conv_done_irq_o), 16'h0);
    chk("collide flag", 16'(conv_done_flag_o), 16'h0);
    wait_hold();
    wr(CHAN_ADDR, 8'h02);
    quiet(100);
    wait_irq(n);
    res_chk(vin[2]);
    wait_hold();
    standby_i = 1'b1;
    quiet(400);
    standby_i = 1'b0;
    wait_hold();
    wr(MODE_ADDR, 8'h01);
    chk("hold", 16'(hold_o), 16'h0);
    quiet(400);
    $display("test abort done");
    wr(MODE_ADDR, 8'hc5);
    quiet(200);
    ext_conv_trigger_i = 1'b1;
    wait_hold();
    ext_conv_trigger_i = 1'b0;
    repeat (5) @(negedge clk_i);
    ext_conv_trigger_i = 1'b1;
    wait_irq(n);
    quiet(400);
    ext_conv_trigger_i = 1'b0;
    repeat (5) @(negedge clk_i);
    ext_conv_trigger_i = 1'b1;
    wait_hold();
    wr(CHAN_ADDR, 8'h05);
    quiet(400);
    ext_conv_trigger_i = 1'b0;
    repeat (5) @(negedge clk_i);
    ext_conv_trigger_i = 1'b1;
    wait_irq(n);
    res_chk(vin[5]);
    // Falling edge selected: the trigger now drops from high
    wr(MODE_ADDR, 8'hc3);
    ext_conv_trigger_i = 1'b0;
    wait_irq(n);
    // No edge selected: toggling the trigger must not start anything
    wr(MODE_ADDR, 8'hc1);
    ext_conv_trigger_i = 1'b1;
    repeat (5) @(negedge clk_i);
    ext_conv_trigger_i = 1'b0;
    quiet(300);
    // Both edges selected: a rise and then a fall each start one conversion
    wr(MODE_ADDR, 8'hc7);
    ext_conv_trigger_i = 1'b1;
    wait_irq(n);
    ext_conv_trigger_i = 1'b0;
    wait_irq(n);
    res_chk(vin[5]);
    $display("test trigger start done");
    stop_test();
  end
endmodule
`default_nettype wire
